/* logic/pacr_map.svh */
// register offsets, field positions and reset values of the address/10bt config bank
`ifndef PACR_MAP_SVH
`define PACR_MAP_SVH
`define PACR_PHY_ADDRESS_REG 5'h19
`define PACR_TENBASE_STATUS_REG 5'h1B
`define PACR_TENBASE_CONFIG_REG 5'h1C
`define PACR_SER_BIT 9
`define PACR_CFG_RSV15 15
`define PACR_CFG_RSV7 7
`define PACR_LP_BIT 5
`define PACR_HB_BIT 4
`define PACR_PAIR_BIT 3
`define PACR_SQUELCH_BIT 2
`define PACR_JAB_BIT 0
`define PACR_CFG_RESET 16'h80B9
`define PACR_CFG_WMASK 16'h80BD
`define PACR_ADDR_W 5
`endif

/* logic/pacr_pkg.sv */
// types shared by the address/10bt config bank
package pacr_pkg;
    typedef enum logic [1:0] {
        PACR_IDLE = 2'b00,
        PACR_CAPTURE = 2'b01,
        PACR_RUN = 2'b10
    } pacr_state_t;
    typedef enum logic {
        PACR_NIBBLE = 1'b0,
        PACR_SERIAL = 1'b1
    } pacr_mii_mode_t;
endpackage : pacr_pkg

/* logic/pacr_mode_logic.sv */
// operating-mode decode from the 10bt configuration bits
`timescale 1ns/10ps
`include "pacr_map.svh"
module pacr_mode_logic (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] cfg,
    input wire logic ser_bit,
    input wire logic speed_100_sel,
    input wire logic autoneg_en,
    input wire logic full_duplex,
    output logic mii_serial,
    output logic link_pulse_tx,
    output logic force_good_link,
    output logic force_10m,
    output logic heartbeat_on,
    output logic utp_oe,
    output logic stp_oe,
    output logic low_squelch,
    output logic jabber_on
);
    logic lp;
    logic at_100;
    assign lp = cfg[`PACR_LP_BIT];
    // link pulse off with autoneg drops the 100 setting to 10
    assign at_100 = speed_100_sel && !(autoneg_en && !lp);

    // registered decode so every output stands on a flop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mii_serial <= 1'b0;
            link_pulse_tx <= 1'b1;
            force_good_link <= 1'b0;
            force_10m <= 1'b0;
            heartbeat_on <= 1'b1;
            utp_oe <= 1'b1;
            stp_oe <= 1'b0;
            low_squelch <= 1'b0;
            jabber_on <= 1'b1;
        end else begin
            mii_serial <= ser_bit && !at_100;
            // at 100 without autoneg the bit is ignored
            link_pulse_tx <= at_100 ? 1'b0 : lp;
            force_good_link <= at_100 ? 1'b0 : !lp;
            force_10m <= speed_100_sel && autoneg_en && !lp;
            heartbeat_on <= cfg[`PACR_HB_BIT] && !full_duplex && !at_100;
            utp_oe <= cfg[`PACR_PAIR_BIT];
            stp_oe <= !cfg[`PACR_PAIR_BIT];
            low_squelch <= cfg[`PACR_SQUELCH_BIT];
            jabber_on <= cfg[`PACR_JAB_BIT] && !at_100;
        end
    end

    // exactly one transmit pair enabled, one cycle after config
    property p_one_pair;
        @(posedge clk) disable iff (rst) utp_oe != stp_oe;
    endproperty
    a_one_pair: assert property (p_one_pair) else $error("both or no pairs enabled");

    property p_no_serial_100;
        @(posedge clk) disable iff (rst) at_100 |=> !mii_serial;
    endproperty
    a_no_serial_100: assert property (p_no_serial_100) else $error("serial mode at 100");
endmodule : pacr_mode_logic

/* logic/pacr_regs.sv */
// address, 10bt status and 10bt configuration registers of the phy
`timescale 1ns/10ps
`include "pacr_map.svh"
module pacr_regs #(
    parameter int STRAP_SETTLE = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [4:0] phy_address_strap_pins,
    input wire logic ten_serial_mode_strap,
    input wire logic [4:0] mgmt_phy_addr,
    input wire logic [4:0] mgmt_reg_addr,
    input wire logic mgmt_wr,
    input wire logic mgmt_rd,
    input wire logic [15:0] mgmt_wdata,
    input wire logic speed_100_sel,
    input wire logic autoneg_en,
    input wire logic full_duplex,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_hit,
    output logic [4:0] phy_address_field,
    output logic isolate_set,
    output logic ten_serial_mode_bit,
    output logic [15:0] tenbase_config,
    output logic mii_serial,
    output logic link_pulse_tx,
    output logic force_good_link,
    output logic force_10m,
    output logic heartbeat_on,
    output logic unshielded_tx_oe,
    output logic shielded_tx_oe,
    output logic low_squelch,
    output logic jabber_on
);
    pacr_pkg::pacr_state_t state;
    logic [1:0] settle_cnt;
    logic addr_match;
    logic wr_addr_reg;
    logic wr_sr;
    logic wr_cr;

    // register strobe decode, shared by the three writable registers
    function automatic logic pacr_sel(input logic strobe, input logic match,
                                      input logic [4:0] reg_addr, input logic [4:0] target);
        return strobe && match && (reg_addr == target);
    endfunction : pacr_sel

    // frames carry the address as shifted in msb first; the serial front end
    // is outside this bank and hands over mgmt_phy_addr already assembled
    assign addr_match = (mgmt_phy_addr == phy_address_field);
    assign wr_addr_reg = pacr_sel(mgmt_wr, addr_match, mgmt_reg_addr, `PACR_PHY_ADDRESS_REG);
    assign wr_sr = pacr_sel(mgmt_wr, addr_match, mgmt_reg_addr, `PACR_TENBASE_STATUS_REG);
    assign wr_cr = pacr_sel(mgmt_wr, addr_match, mgmt_reg_addr, `PACR_TENBASE_CONFIG_REG);

    // strap capture sequence: async reset takes constants, straps are
    // sampled by the clock after release so no port feeds a reset value
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= pacr_pkg::PACR_IDLE;
            settle_cnt <= 2'h0;
        end else begin
            case (state)
                pacr_pkg::PACR_IDLE: begin
                    if (settle_cnt == 2'(STRAP_SETTLE - 1)) begin
                        state <= pacr_pkg::PACR_CAPTURE;
                    end else begin
                        settle_cnt <= settle_cnt + 2'h1;
                    end
                end
                pacr_pkg::PACR_CAPTURE: state <= pacr_pkg::PACR_RUN;
                pacr_pkg::PACR_RUN: state <= pacr_pkg::PACR_RUN;
                default: state <= pacr_pkg::PACR_IDLE;
            endcase
        end
    end

    // address field: strap load then software writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phy_address_field <= 5'h00;
        end else if (state == pacr_pkg::PACR_CAPTURE) begin
            phy_address_field <= phy_address_strap_pins;
        end else if (wr_addr_reg && state == pacr_pkg::PACR_RUN) begin
            phy_address_field <= mgmt_wdata[4:0];
        end
    end

    // isolate request follows the address; zero strap at reset isolates too
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            isolate_set <= 1'b0;
        end else begin
            isolate_set <= (phy_address_field == 5'h00) && state == pacr_pkg::PACR_RUN;
        end
    end

    // serial-mode bit: strap load then software writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ten_serial_mode_bit <= 1'b0;
        end else if (state == pacr_pkg::PACR_CAPTURE) begin
            ten_serial_mode_bit <= ten_serial_mode_strap;
        end else if (wr_sr && state == pacr_pkg::PACR_RUN) begin
            ten_serial_mode_bit <= mgmt_wdata[`PACR_SER_BIT];
        end
    end

    // config register: only writable bits store; read-only reserved read 0.
    // bits 15 and 7 are kept writable so software's ones stick
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tenbase_config <= `PACR_CFG_RESET;
        end else if (wr_cr && state == pacr_pkg::PACR_RUN) begin
            tenbase_config <= mgmt_wdata & `PACR_CFG_WMASK;
        end
    end

    // read data registered, one cycle after mgmt_rd
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mgmt_rdata <= 16'h0000;
            mgmt_hit <= 1'b0;
        end else begin
            mgmt_rdata <= 16'h0000;
            mgmt_hit <= 1'b0;
            if (mgmt_rd && addr_match) begin
                case (mgmt_reg_addr)
                    `PACR_PHY_ADDRESS_REG: begin
                        mgmt_rdata <= {11'h000, phy_address_field};
                        mgmt_hit <= 1'b1;
                    end
                    `PACR_TENBASE_STATUS_REG: begin
                        mgmt_rdata <= {6'h00, ten_serial_mode_bit, 9'h000};
                        mgmt_hit <= 1'b1;
                    end
                    `PACR_TENBASE_CONFIG_REG: begin
                        mgmt_rdata <= tenbase_config;
                        mgmt_hit <= 1'b1;
                    end
                    default: mgmt_hit <= 1'b0;
                endcase
            end
        end
    end

    pacr_mode_logic i_pacr_mode_logic (
        .clk(clk),
        .rst(rst),
        .cfg(tenbase_config),
        .ser_bit(ten_serial_mode_bit),
        .speed_100_sel(speed_100_sel),
        .autoneg_en(autoneg_en),
        .full_duplex(full_duplex),
        .mii_serial(mii_serial),
        .link_pulse_tx(link_pulse_tx),
        .force_good_link(force_good_link),
        .force_10m(force_10m),
        .heartbeat_on(heartbeat_on),
        .utp_oe(unshielded_tx_oe),
        .stp_oe(shielded_tx_oe),
        .low_squelch(low_squelch),
        .jabber_on(jabber_on)
    );

    property p_strap_load;
        @(posedge clk) disable iff (rst)
            state == pacr_pkg::PACR_CAPTURE |=> phy_address_field == $past(phy_address_strap_pins);
    endproperty
    a_strap_load: assert property (p_strap_load) else $error("address strap not loaded");

    property p_isolate;
        @(posedge clk) disable iff (rst)
            (state == pacr_pkg::PACR_RUN && phy_address_field == 5'h00) |=> isolate_set;
    endproperty
    a_isolate: assert property (p_isolate) else $error("zero address did not isolate");

    property p_ser_strap;
        @(posedge clk) disable iff (rst)
            state == pacr_pkg::PACR_CAPTURE |=> ten_serial_mode_bit == $past(ten_serial_mode_strap);
    endproperty
    a_ser_strap: assert property (p_ser_strap) else $error("serial strap not latched");

    property p_mii_mode;
        @(posedge clk) disable iff (rst)
            (!speed_100_sel && $stable(ten_serial_mode_bit)) |=> mii_serial == $past(ten_serial_mode_bit);
    endproperty
    a_mii_mode: assert property (p_mii_mode) else $error("mii mode wrong at 10");

    property p_lp_off;
        @(posedge clk) disable iff (rst)
            (!speed_100_sel && !tenbase_config[`PACR_LP_BIT]) |=> (!link_pulse_tx && force_good_link);
    endproperty
    a_lp_off: assert property (p_lp_off) else $error("link pulse off not honoured");

    property p_force10;
        @(posedge clk) disable iff (rst)
            (speed_100_sel && autoneg_en && !tenbase_config[`PACR_LP_BIT]) |=> force_10m;
    endproperty
    a_force10: assert property (p_force10) else $error("10 Mb/s not forced");

    property p_lp_ignored;
        @(posedge clk) disable iff (rst)
            (speed_100_sel && !autoneg_en) |=> (!link_pulse_tx && !force_good_link && !force_10m);
    endproperty
    a_lp_ignored: assert property (p_lp_ignored) else $error("link pulse bit acted at 100");

    property p_hb;
        @(posedge clk) disable iff (rst) full_duplex |=> !heartbeat_on;
    endproperty
    a_hb: assert property (p_hb) else $error("heartbeat in full duplex");

    property p_cfg_write;
        @(posedge clk) disable iff (rst)
            (wr_cr && state == pacr_pkg::PACR_RUN) |=> ##1 low_squelch == $past(mgmt_wdata[2], 2);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("squelch write lost");

    // a software address write lands on the next edge
    property p_addr_write;
        @(posedge clk) disable iff (rst) (wr_addr_reg && state == pacr_pkg::PACR_RUN)
            |=> phy_address_field == $past(mgmt_wdata[4:0]);
    endproperty
    a_addr_write: assert property (p_addr_write) else $error("address write lost");

    // serial-mode bit follows a software write to the status register
    property p_ser_write;
        @(posedge clk) disable iff (rst) (wr_sr && state == pacr_pkg::PACR_RUN)
            |=> ten_serial_mode_bit == $past(mgmt_wdata[`PACR_SER_BIT]);
    endproperty
    a_ser_write: assert property (p_ser_write) else $error("serial bit write lost");

    // config keeps only the writable bits of a write
    property p_cfg_mask;
        @(posedge clk) disable iff (rst) (wr_cr && state == pacr_pkg::PACR_RUN)
            |=> tenbase_config == ($past(mgmt_wdata) & `PACR_CFG_WMASK);
    endproperty
    a_cfg_mask: assert property (p_cfg_mask) else $error("config mask wrong");

    // strap fields must not move while the straps settle
    property p_idle_hold;
        @(posedge clk) disable iff (rst) state == pacr_pkg::PACR_IDLE
            |=> $stable(phy_address_field) && $stable(ten_serial_mode_bit);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("field moved early");

    // selected pair tracks the config bit a cycle later; catches a swapped pair
    property p_pair_follow;
        @(posedge clk) disable iff (rst) 1'b1
            |=> unshielded_tx_oe == $past(tenbase_config[`PACR_PAIR_BIT]);
    endproperty
    a_pair_follow: assert property (p_pair_follow) else $error("pair select not followed");

    // jabber has no meaning at 100, so it is held off there
    property p_jabber_100;
        @(posedge clk) disable iff (rst) (speed_100_sel && !autoneg_en)
            |=> !jabber_on;
    endproperty
    a_jabber_100: assert property (p_jabber_100) else $error("jabber active at 100");

    // a frame for another phy gets neither data nor a hit
    property p_read_refused;
        @(posedge clk) disable iff (rst) (mgmt_rd && !addr_match)
            |=> (!mgmt_hit && mgmt_rdata == 16'h0000);
    endproperty
    a_read_refused: assert property (p_read_refused) else $error("foreign read answered");

    // address register read returns the field as it stood at the request
    property p_read_addr;
        @(posedge clk) disable iff (rst)
            (mgmt_rd && addr_match && mgmt_reg_addr == `PACR_PHY_ADDRESS_REG)
            |=> (mgmt_hit && mgmt_rdata == {11'h000, $past(phy_address_field)});
    endproperty
    a_read_addr: assert property (p_read_addr) else $error("address read wrong");

    // a nonzero address releases the isolate request
    property p_isolate_clear;
        @(posedge clk) disable iff (rst)
            (state == pacr_pkg::PACR_RUN && phy_address_field != 5'h00) |=> !isolate_set;
    endproperty
    a_isolate_clear: assert property (p_isolate_clear) else $error("isolate held");

    // heartbeat runs at 10 half duplex when its bit is set
    property p_hb_on;
        @(posedge clk) disable iff (rst)
            (tenbase_config[`PACR_HB_BIT] && !full_duplex && !speed_100_sel) |=> heartbeat_on;
    endproperty
    a_hb_on: assert property (p_hb_on) else $error("heartbeat not on");
endmodule : pacr_regs

/* tb/pacr_mgmt_model.sv */
// management-side model that issues register reads and writes
`timescale 1ns/10ps
module pacr_mgmt_model (
    input wire logic clk,
    input wire logic [15:0] mgmt_rdata,
    input wire logic mgmt_hit,
    output logic [4:0] mgmt_phy_addr,
    output logic [4:0] mgmt_reg_addr,
    output logic mgmt_wr,
    output logic mgmt_rd,
    output logic [15:0] mgmt_wdata
);
    initial begin
        mgmt_phy_addr = 5'h1F;
        mgmt_reg_addr = 5'h00;
        mgmt_wr = 1'b0;
        mgmt_rd = 1'b0;
        mgmt_wdata = 16'h0000;
    end
    // one request held to its taking edge; then reg address and write data are scrambled, phy address is kept
    task automatic xfer(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d,
                        input logic w, output logic [15:0] q, output logic h);
        @(posedge clk);
        #1;
        mgmt_phy_addr = pa;
        mgmt_reg_addr = ra;
        mgmt_wdata = (ra == 5'h1C) ? ((d & 16'h003D) | 16'h8080) : d;
        mgmt_wr = w;
        mgmt_rd = !w;
        @(posedge clk);
        #1;
        q = mgmt_rdata;
        h = mgmt_hit;
        mgmt_wr = 1'b0;
        mgmt_rd = 1'b0;
        mgmt_reg_addr = ~mgmt_reg_addr;
        mgmt_wdata = ~mgmt_wdata;
    endtask : xfer
endmodule : pacr_mgmt_model

/* tb/testbench.sv */
// self-checking bench for the address and 10bt configuration registers
`timescale 1ns/10ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] straps = 5'h0A;
    logic ser_strap = 1'b1;
    logic sp100 = 1'b0;
    logic an = 1'b0;
    logic fd = 1'b0;
    logic [4:0] pa;
    logic [4:0] ra;
    logic wr_s;
    logic rd_s;
    logic [15:0] wd;
    logic [15:0] rdata;
    logic hit;
    logic [4:0] phy_address_field;
    logic isolate_set;
    logic ten_serial_mode_bit;
    logic [15:0] tenbase_config;
    logic mii_serial, link_pulse_tx, force_good_link, force_10m, heartbeat_on;
    logic unshielded_tx_oe, shielded_tx_oe, low_squelch, jabber_on;
    logic [15:0] mode;
    logic [15:0] q;
    logic h;
    int bad_count = 0;
    int checked = 0;
    // decoded outputs packed for one compare per state
    assign mode = {7'h00, mii_serial, link_pulse_tx, force_good_link, force_10m,
                   heartbeat_on, unshielded_tx_oe, shielded_tx_oe, low_squelch, jabber_on};
    always #20 clk = ~clk;
    pacr_regs #(.STRAP_SETTLE(2)) i_pacr_regs (
        .clk(clk), .rst(rst), .phy_address_strap_pins(straps),
        .ten_serial_mode_strap(ser_strap), .mgmt_phy_addr(pa), .mgmt_reg_addr(ra),
        .mgmt_wr(wr_s), .mgmt_rd(rd_s), .mgmt_wdata(wd), .speed_100_sel(sp100),
        .autoneg_en(an), .full_duplex(fd), .mgmt_rdata(rdata), .mgmt_hit(hit),
        .phy_address_field(phy_address_field), .isolate_set(isolate_set),
        .ten_serial_mode_bit(ten_serial_mode_bit), .tenbase_config(tenbase_config),
        .mii_serial(mii_serial), .link_pulse_tx(link_pulse_tx),
        .force_good_link(force_good_link), .force_10m(force_10m),
        .heartbeat_on(heartbeat_on), .unshielded_tx_oe(unshielded_tx_oe),
        .shielded_tx_oe(shielded_tx_oe), .low_squelch(low_squelch), .jabber_on(jabber_on)
    );
    pacr_mgmt_model i_pacr_mgmt_model (
        .clk(clk), .mgmt_rdata(rdata), .mgmt_hit(hit), .mgmt_phy_addr(pa),
        .mgmt_reg_addr(ra), .mgmt_wr(wr_s), .mgmt_rd(rd_s), .mgmt_wdata(wd)
    );
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // write, then let the decoded outputs settle one cycle past the store
    task automatic wr(input logic [4:0] a, input logic [4:0] r, input logic [15:0] d);
        i_pacr_mgmt_model.xfer(a, r, d, 1'b1, q, h);
        repeat (2) @(posedge clk);
        #1;
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [4:0] r, input logic [15:0] e,
                      input logic eh);
        i_pacr_mgmt_model.xfer(a, r, 16'h0000, 1'b0, q, h);
        chk(q, e);
        chk({15'h0000, h}, {15'h0000, eh});
    endtask : rd
    task automatic env(input logic s, input logic n, input logic f);
        @(posedge clk);
        #1;
        sp100 = s;
        an = n;
        fd = f;
        repeat (2) @(posedge clk);
        #1;
    endtask : env
    task automatic do_reset();
        rst = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (5) @(posedge clk);
        #1;
    endtask : do_reset
    task automatic conclude();
        if (bad_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    // a hang ends the run as a failure
    initial begin
        #60000;
        bad_count++;
        conclude();
    end
    // register scenarios in order, closed by a second reset
    initial begin
        do_reset();
        chk({11'h000, phy_address_field}, 16'h000A);
        chk({15'h0000, ten_serial_mode_bit}, 16'h0001);
        chk(tenbase_config, 16'h80B9);
        chk(mode, 16'h0199);
        rd(5'h0A, 5'h19, 16'h000A, 1'b1);
        rd(5'h0A, 5'h1B, 16'h0200, 1'b1);
        rd(5'h0A, 5'h1C, 16'h80B9, 1'b1);
        rd(5'h0A, 5'h1D, 16'h0000, 1'b0);
        rd(5'h0B, 5'h19, 16'h0000, 1'b0);
        wr(5'h0A, 5'h1C, 16'hFFFF);
        rd(5'h0A, 5'h1C, 16'h80BD, 1'b1);
        chk(mode, 16'h019B);
        wr(5'h0B, 5'h1C, 16'h0000);
        rd(5'h0A, 5'h1C, 16'h80BD, 1'b1);
        wr(5'h0A, 5'h1C, 16'h0000);
        chk(mode, 16'h0144);
        env(1'b1, 1'b1, 1'b0);
        chk(mode, 16'h0164);
        env(1'b1, 1'b0, 1'b0);
        chk({13'h0000, mii_serial, force_10m, heartbeat_on}, 16'h0000);
        wr(5'h0A, 5'h1C, 16'hFFFF);
        chk({10'h000, mii_serial, force_10m, heartbeat_on, jabber_on, link_pulse_tx,
             force_good_link}, 16'h0000);
        env(1'b0, 1'b0, 1'b1);
        chk({15'h0000, heartbeat_on}, 16'h0000);
        env(1'b0, 1'b0, 1'b0);
        wr(5'h0A, 5'h1B, 16'h0000);
        chk({15'h0000, mii_serial}, 16'h0000);
        wr(5'h0A, 5'h19, 16'h0000);
        chk({15'h0000, isolate_set}, 16'h0001);
        wr(5'h00, 5'h19, 16'h0015);
        chk({15'h0000, isolate_set}, 16'h0000);
        rd(5'h15, 5'h19, 16'h0015, 1'b1);
        // an asymmetric address: the bit-reversed form must not match
        wr(5'h15, 5'h19, 16'h0001);
        rd(5'h10, 5'h19, 16'h0000, 1'b0);
        rd(5'h01, 5'h19, 16'h0001, 1'b1);
        // second reset with every strap low
        straps = 5'h00;
        ser_strap = 1'b0;
        do_reset();
        chk({10'h000, phy_address_field, ten_serial_mode_bit}, 16'h0000);
        chk({15'h0000, isolate_set}, 16'h0001);
        conclude();
    end
endmodule : testbench
